// file: logic/pmux_cfg.svh
/*
  Offsets, field positions, reset values and fixed codes of the port pin override block.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef PMUX_CFG_SVH
`define PMUX_CFG_SVH

// Register byte offsets, compared on haddr[7:0]
`define PMUX_OFF_SFC 8'h00
`define PMUX_OFF_PA_DIR 8'h04
`define PMUX_OFF_PA_LATCH 8'h08
`define PMUX_OFF_PA_PINS 8'h0c
`define PMUX_OFF_PB_DIR 8'h10
`define PMUX_OFF_PB_LATCH 8'h14
`define PMUX_OFF_PB_PINS 8'h18

// Special function control fields
`define PMUX_SFC_TIMER_SYNC_MODE 7
`define PMUX_SFC_COMPARATOR_MUX_ENABLE 3
`define PMUX_SFC_GLOBAL_PULLUP_OFF 2
`define PMUX_SFC_TIMER0_PRESCALER_RESET 1
`define PMUX_SFC_TIMER123_PRESCALER_RESET 0
`define PMUX_SFC_WRITE_MASK 8'h8f
`define PMUX_SFC_RESET 8'h00

// Port register reset values
`define PMUX_PORT_RESET 8'h00

// Bus codes
`define PMUX_HRESP_OKAY 1'b0
`define PMUX_RDATA_ZERO 32'h0000_0000

`endif

// file: logic/pmux_pkg.sv
/*
  Types shared by the port pin override block.
  Assumes pmux_cfg.svh sits beside this file.
*/
package pmux_pkg;
  `include "pmux_cfg.svh"

  typedef logic [7:0] pmux_byte_t;

  typedef enum logic [1:0] {
    PMUX_HTRANS_IDLE = 2'b00,
    PMUX_HTRANS_BUSY = 2'b01,
    PMUX_HTRANS_NONSEQ = 2'b10,
    PMUX_HTRANS_SEQ = 2'b11
  } pmux_htrans_t;
endpackage : pmux_pkg

// file: logic/pmux_pin_cell.sv
/*
  Combinational override resolution for eight pins of one port.
  Assumes override signals and register bits are on the same clock; outputs are registered by the caller.
*/
`timescale 1ns/1ps
module pmux_pin_cell
  import pmux_pkg::*;
(
  // Port register bits
  input wire pmux_byte_t i_pin_direction_bit,
  input wire pmux_byte_t i_pin_output_latch,
  input wire logic i_global_pullup_off,
  // Override set
  input wire pmux_byte_t i_pullup_override_enable,
  input wire pmux_byte_t i_pullup_override_value,
  input wire pmux_byte_t i_direction_override_enable,
  input wire pmux_byte_t i_direction_override_value,
  input wire pmux_byte_t i_value_override_enable,
  input wire pmux_byte_t i_value_override_value,
  // Resolved pin controls
  output logic [7:0] o_pullup,
  output logic [7:0] o_drive_enable,
  output logic [7:0] o_drive_value
);
  pmux_byte_t plain_pullup;

  // Plain pull-up only for pattern {dir, latch, off} = 0b010
  assign plain_pullup = ~i_pin_direction_bit & i_pin_output_latch & {8{~i_global_pullup_off}};

  assign o_pullup = (i_pullup_override_enable & i_pullup_override_value) |
                    (~i_pullup_override_enable & plain_pullup);
  assign o_drive_enable = (i_direction_override_enable & i_direction_override_value) |
                          (~i_direction_override_enable & i_pin_direction_bit);
  assign o_drive_value = (i_value_override_enable & i_value_override_value) |
                         (~i_value_override_enable & i_pin_output_latch);
endmodule : pmux_pin_cell

// file: logic/pmux_top.sv
/*
  Port A / Port B pin override logic with an AHB-Lite register slave.
  Assumes one 200 MHz clock; memory interface, timers and SPI run on it; pins arrive asynchronously.
*/
// The implementer's own choices: the register offsets and the AHB-Lite register port.
// What this block does
// - Global pull-up off kills every pull-up
// - Control register resets zero; bits 6..4 read zero
// - Port A carries muxed address/data byte
// - Memory enable takes over Port A pins
// - Drive address or data during active phases
// - Lower Port A pins handled identically
// - Port A input feeds memory; gate override zero
// - Bit 7 outputs timer 2 or timer 1C
// - Bit 6 outputs timer 1 compare B
// - Bit 5 outputs timer 1 compare A
// - Bit 4 outputs timer 0 compare
// - Compare outputs also carry PWM waveforms
// - Legacy mode drops timer 1C on bit 7
// - Port B 3..0 carry SPI signals
// - Pull-up follows override, else pattern 0b010
// - Driver follows direction override, else direction bit
// - Pin value follows override, else output latch
`timescale 1ns/1ps
module pmux_top
  import pmux_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // External memory interface
  input wire logic i_ext_memory_enable,
  input wire logic i_write_phase,
  input wire logic i_address_active,
  input wire logic [7:0] i_mem_addr_lo,
  input wire logic [7:0] i_mem_data_out,
  output logic [7:0] o_mem_data_in,
  // Timer compare outputs and their enables
  input wire logic i_timer2_compare_out,
  input wire logic i_timer2_compare_en,
  input wire logic i_timer1_compare_c_out,
  input wire logic i_timer1_compare_c_en,
  input wire logic i_timer1_compare_b_out,
  input wire logic i_timer1_compare_b_en,
  input wire logic i_timer1_compare_a_out,
  input wire logic i_timer1_compare_a_en,
  input wire logic i_timer0_compare_out,
  input wire logic i_timer0_compare_en,
  input wire logic i_legacy_mode,
  // SPI unit
  input wire logic i_spi_enable,
  input wire logic i_spi_master,
  input wire logic i_spi_slave_out,
  input wire logic i_spi_master_out,
  input wire logic i_spi_sck_out,
  output logic o_spi_master_in,
  output logic o_spi_slave_in,
  output logic o_spi_sck_in,
  output logic o_spi_select_n,
  // Control bits to other units
  output logic o_timer_sync_mode,
  output logic o_comparator_mux_enable,
  output logic o_global_pullup_off,
  output logic o_timer0_prescaler_reset,
  output logic o_timer123_prescaler_reset,
  // Port A pins
  input wire logic [7:0] i_pa_pin,
  output logic [7:0] o_pa_out,
  output logic [7:0] o_pa_oe,
  output logic [7:0] o_pa_pullup,
  output logic [7:0] o_pa_input_gate_override_enable,
  // Port B pins
  input wire logic [7:0] i_pb_pin,
  output logic [7:0] o_pb_out,
  output logic [7:0] o_pb_oe,
  output logic [7:0] o_pb_pullup
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  pmux_byte_t special_function_control_q;
  pmux_byte_t pa_dir_q;
  pmux_byte_t pa_latch_q;
  pmux_byte_t pb_dir_q;
  pmux_byte_t pb_latch_q;
  pmux_byte_t pa_sync1_q;
  pmux_byte_t pa_sync2_q;
  pmux_byte_t pb_sync1_q;
  pmux_byte_t pb_sync2_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic addr_phase;
  logic [31:0] rdata_d;
  logic pullup_off;

  pmux_byte_t pa_pu_ovr_en, pa_pu_ovr_v, pa_oe_ovr_en, pa_oe_ovr_v, pa_val_ovr_en, pa_val_ovr_v;
  pmux_byte_t pb_pu_ovr_en, pb_pu_ovr_v, pb_oe_ovr_en, pb_oe_ovr_v, pb_val_ovr_en, pb_val_ovr_v;
  logic [7:0] pa_pullup_d, pa_oe_d, pa_out_d;
  logic [7:0] pb_pullup_d, pb_oe_d, pb_out_d;
  logic mem_drive;
  logic spi_as_master;
  logic spi_as_slave;
  logic [3:0] spi_force_in;
  logic bit7_t1c_en;
  logic bit7_value;

  // Widens a byte register to the bus word, upper bits zero
  function automatic logic [31:0] word_of(input pmux_byte_t b);
    word_of = {24'h00_0000, b};
  endfunction : word_of

  // True when an offset selects a given register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait, reads registered at address phase

  assign addr_phase = i_hsel & i_hready & i_htrans[1];
  assign o_hreadyout = 1'b1;
  assign o_hresp = `PMUX_HRESP_OKAY;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (i_hready) begin
      wr_pend_q <= addr_phase & i_hwrite;
      wr_addr_q <= i_haddr[7:0];
    end
  end

  always_comb begin
    rdata_d = `PMUX_RDATA_ZERO;
    if (hit(i_haddr[7:0], `PMUX_OFF_SFC)) begin
      rdata_d = word_of(special_function_control_q);
    end else if (hit(i_haddr[7:0], `PMUX_OFF_PA_DIR)) begin
      rdata_d = word_of(pa_dir_q);
    end else if (hit(i_haddr[7:0], `PMUX_OFF_PA_LATCH)) begin
      rdata_d = word_of(pa_latch_q);
    end else if (hit(i_haddr[7:0], `PMUX_OFF_PA_PINS)) begin
      rdata_d = word_of(pa_sync2_q);
    end else if (hit(i_haddr[7:0], `PMUX_OFF_PB_DIR)) begin
      rdata_d = word_of(pb_dir_q);
    end else if (hit(i_haddr[7:0], `PMUX_OFF_PB_LATCH)) begin
      rdata_d = word_of(pb_latch_q);
    end else if (hit(i_haddr[7:0], `PMUX_OFF_PB_PINS)) begin
      rdata_d = word_of(pb_sync2_q);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_hrdata <= `PMUX_RDATA_ZERO;
    end else if (addr_phase & ~i_hwrite) begin
      o_hrdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      special_function_control_q <= `PMUX_SFC_RESET;
    end else if (wr_pend_q && hit(wr_addr_q, `PMUX_OFF_SFC)) begin
      special_function_control_q <= i_hwdata[7:0] & `PMUX_SFC_WRITE_MASK;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pa_dir_q <= `PMUX_PORT_RESET;
      pa_latch_q <= `PMUX_PORT_RESET;
      pb_dir_q <= `PMUX_PORT_RESET;
      pb_latch_q <= `PMUX_PORT_RESET;
    end else if (wr_pend_q) begin
      if (hit(wr_addr_q, `PMUX_OFF_PA_DIR)) begin
        pa_dir_q <= i_hwdata[7:0];
      end
      if (hit(wr_addr_q, `PMUX_OFF_PA_LATCH)) begin
        pa_latch_q <= i_hwdata[7:0];
      end
      if (hit(wr_addr_q, `PMUX_OFF_PB_DIR)) begin
        pb_dir_q <= i_hwdata[7:0];
      end
      if (hit(wr_addr_q, `PMUX_OFF_PB_LATCH)) begin
        pb_latch_q <= i_hwdata[7:0];
      end
    end
  end

  assign pullup_off = special_function_control_q[`PMUX_SFC_GLOBAL_PULLUP_OFF];
  assign o_timer_sync_mode = special_function_control_q[`PMUX_SFC_TIMER_SYNC_MODE];
  assign o_comparator_mux_enable = special_function_control_q[`PMUX_SFC_COMPARATOR_MUX_ENABLE];
  assign o_global_pullup_off = pullup_off;
  assign o_timer0_prescaler_reset = special_function_control_q[`PMUX_SFC_TIMER0_PRESCALER_RESET];
  assign o_timer123_prescaler_reset = special_function_control_q[`PMUX_SFC_TIMER123_PRESCALER_RESET];

  ////////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pa_sync1_q <= 8'h00;
      pa_sync2_q <= 8'h00;
      pb_sync1_q <= 8'h00;
      pb_sync2_q <= 8'h00;
    end else begin
      pa_sync1_q <= i_pa_pin;
      pa_sync2_q <= pa_sync1_q;
      pb_sync1_q <= i_pb_pin;
      pb_sync2_q <= pb_sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port A: external memory takeover

  // Memory controls enter as plain same-clock inputs
  assign mem_drive = i_write_phase | i_address_active;
  assign pa_pu_ovr_en = {8{i_ext_memory_enable}};
  assign pa_oe_ovr_en = {8{i_ext_memory_enable}};
  assign pa_val_ovr_en = {8{i_ext_memory_enable}};
  assign pa_pu_ovr_v = {8{~mem_drive}} & pa_latch_q & {8{~pullup_off}};
  assign pa_oe_ovr_v = {8{mem_drive}};
  assign pa_val_ovr_v = (i_mem_addr_lo & {8{i_address_active}}) | (i_mem_data_out & {8{i_write_phase}});

  ////////////////////////////////////////////////////////////////////////////////
  // Port B: timer compares and SPI

  // Both bit 7 sources active: modulated, latch bit 7 picks OR (1) or AND (0)
  assign bit7_t1c_en = i_timer1_compare_c_en & ~i_legacy_mode;
  always_comb begin
    bit7_value = i_timer2_compare_out;
    if (bit7_t1c_en && !i_timer2_compare_en) begin
      bit7_value = i_timer1_compare_c_out;
    end else if (bit7_t1c_en && i_timer2_compare_en) begin
      bit7_value = pb_latch_q[7] ? (i_timer2_compare_out | i_timer1_compare_c_out)
                                 : (i_timer2_compare_out & i_timer1_compare_c_out);
    end
  end

  assign spi_as_master = i_spi_enable & i_spi_master;
  assign spi_as_slave = i_spi_enable & ~i_spi_master;
  // Input-forced SPI pins: data in on the master, the rest on the slave
  assign spi_force_in = {spi_as_master, {3{spi_as_slave}}};

  // Timer waveforms, PWM included, pass straight through; direction stays software's
  assign pb_val_ovr_en = {i_timer2_compare_en | bit7_t1c_en, i_timer1_compare_b_en,
                          i_timer1_compare_a_en, i_timer0_compare_en,
                          spi_as_slave, spi_as_master, spi_as_master, 1'b0};
  assign pb_val_ovr_v = {bit7_value, i_timer1_compare_b_out, i_timer1_compare_a_out, i_timer0_compare_out,
                         i_spi_slave_out, i_spi_master_out, i_spi_sck_out, 1'b0};
  assign pb_pu_ovr_en = {4'h0, spi_force_in};
  assign pb_pu_ovr_v = {4'h0, pb_latch_q[3:0] & {4{~pullup_off}}};
  assign pb_oe_ovr_en = {4'h0, spi_force_in};
  assign pb_oe_ovr_v = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Resolution and registered pin controls

  pmux_pin_cell u_cell_a (
    .i_pin_direction_bit(pa_dir_q),
    .i_pin_output_latch(pa_latch_q),
    .i_global_pullup_off(pullup_off),
    .i_pullup_override_enable(pa_pu_ovr_en),
    .i_pullup_override_value(pa_pu_ovr_v),
    .i_direction_override_enable(pa_oe_ovr_en),
    .i_direction_override_value(pa_oe_ovr_v),
    .i_value_override_enable(pa_val_ovr_en),
    .i_value_override_value(pa_val_ovr_v),
    .o_pullup(pa_pullup_d),
    .o_drive_enable(pa_oe_d),
    .o_drive_value(pa_out_d)
  );

  pmux_pin_cell u_cell_b (
    .i_pin_direction_bit(pb_dir_q),
    .i_pin_output_latch(pb_latch_q),
    .i_global_pullup_off(pullup_off),
    .i_pullup_override_enable(pb_pu_ovr_en),
    .i_pullup_override_value(pb_pu_ovr_v),
    .i_direction_override_enable(pb_oe_ovr_en),
    .i_direction_override_value(pb_oe_ovr_v),
    .i_value_override_enable(pb_val_ovr_en),
    .i_value_override_value(pb_val_ovr_v),
    .o_pullup(pb_pullup_d),
    .o_drive_enable(pb_oe_d),
    .o_drive_value(pb_out_d)
  );

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pa_out <= 8'h00;
      o_pa_oe <= 8'h00;
      o_pa_pullup <= 8'h00;
      o_pb_out <= 8'h00;
      o_pb_oe <= 8'h00;
      o_pb_pullup <= 8'h00;
    end else begin
      o_pa_out <= pa_out_d;
      o_pa_oe <= pa_oe_d;
      o_pa_pullup <= pa_pullup_d & ~pa_oe_d;
      o_pb_out <= pb_out_d;
      o_pb_oe <= pb_oe_d;
      o_pb_pullup <= pb_pullup_d & ~pb_oe_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mem_data_in <= 8'h00;
      o_pa_input_gate_override_enable <= 8'h00;
      o_spi_master_in <= 1'b0;
      o_spi_slave_in <= 1'b0;
      o_spi_sck_in <= 1'b0;
      o_spi_select_n <= 1'b1;
    end else begin
      o_mem_data_in <= pa_sync2_q;
      o_pa_input_gate_override_enable <= 8'h00;
      o_spi_master_in <= pb_sync2_q[3];
      o_spi_slave_in <= pb_sync2_q[2];
      o_spi_sck_in <= pb_sync2_q[1];
      o_spi_select_n <= pb_sync2_q[0];
    end
  end
endmodule : pmux_top

// file: verif/pmux_top_assertions.sv
/* Checker for pmux_top pin controls.
   Assumes binding to pmux_top; sees its ports only. */
`timescale 1ns/1ps
module pmux_top_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Causes
  input wire logic i_ext_memory_enable,
  input wire logic i_write_phase,
  input wire logic i_address_active,
  input wire logic [7:0] i_mem_addr_lo,
  input wire logic [7:0] i_mem_data_out,
  input wire logic i_timer2_compare_out,
  input wire logic i_timer2_compare_en,
  input wire logic i_timer1_compare_b_out,
  input wire logic i_timer1_compare_b_en,
  input wire logic i_legacy_mode,
  input wire logic [7:0] i_pa_pin,
  // Effects
  input wire logic [7:0] o_mem_data_in,
  input wire logic o_global_pullup_off,
  input wire logic [7:0] o_pa_out,
  input wire logic [7:0] o_pa_oe,
  input wire logic [7:0] o_pa_pullup,
  input wire logic [7:0] o_pa_input_gate_override_enable,
  input wire logic [7:0] o_pb_out,
  input wire logic [7:0] o_pb_oe,
  input wire logic [7:0] o_pb_pullup
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_pullup_off_all: assert property (
    o_global_pullup_off && $past(o_global_pullup_off) |-> o_pa_pullup == 8'h00 && o_pb_pullup == 8'h00)
    else $error("pull-up on while disabled");
  a_mem_drive_en: assert property (
    $past(i_ext_memory_enable) |-> o_pa_oe == {8{$past(i_write_phase || i_address_active)}})
    else $error("port A drive enable wrong under memory");
  a_mem_drive_val: assert property (
    $past(i_ext_memory_enable) |->
    o_pa_out == $past((i_mem_addr_lo & {8{i_address_active}}) | (i_mem_data_out & {8{i_write_phase}})))
    else $error("port A value wrong under memory");
  a_mem_pullup: assert property (
    $past(i_ext_memory_enable && (i_write_phase || i_address_active)) |-> o_pa_pullup == 8'h00)
    else $error("port A pull-up on while bus drives");
  a_gate_zero: assert property (o_pa_input_gate_override_enable == 8'h00)
    else $error("input gate override set");
  a_mem_data_in: assert property (o_mem_data_in == $past(i_pa_pin, 3))
    else $error("memory data input not pin after three edges");
  a_legacy_pb7: assert property (
    $past(i_legacy_mode && i_timer2_compare_en) && o_pb_oe[7] |-> o_pb_out[7] == $past(i_timer2_compare_out))
    else $error("bit 7 not timer 2 in legacy mode");
  a_pb6_compare: assert property (
    $past(i_timer1_compare_b_en) && o_pb_oe[6] |-> o_pb_out[6] == $past(i_timer1_compare_b_out))
    else $error("bit 6 not timer 1 compare B");
endmodule : pmux_top_chk

bind pmux_top pmux_top_chk i_chk (.i_clk, .i_arst_n, .i_ext_memory_enable, .i_write_phase,
  .i_address_active, .i_mem_addr_lo, .i_mem_data_out, .i_timer2_compare_out, .i_timer2_compare_en,
  .i_timer1_compare_b_out, .i_timer1_compare_b_en, .i_legacy_mode, .i_pa_pin, .o_mem_data_in,
  .o_global_pullup_off, .o_pa_out, .o_pa_oe, .o_pa_pullup, .o_pa_input_gate_override_enable,
  .o_pb_out, .o_pb_oe, .o_pb_pullup);

// file: verif/pmux_far_model.sv
/* Far-side model: memory interface cycles and timer PWM waveforms.
   Assumes the bench holds i_en as a level and pulses i_go. */
`timescale 1ns/1ps
module pmux_far_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Bench control
  input wire logic i_en,
  input wire logic i_go,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_data,
  // Memory interface
  output logic o_ext_memory_enable,
  output logic o_write_phase,
  output logic o_address_active,
  output logic [7:0] o_mem_addr_lo,
  output logic [7:0] o_mem_data_out,
  // Timer waveforms t2, t1c, t1b, t1a, t0
  output logic [4:0] o_wave
);
  logic [2:0] phase_q;
  logic [3:0] cnt_q;
  // Two address cycles, two write cycles, then release
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_q <= 3'h0;
    end else if (phase_q != 3'h0) begin
      phase_q <= (phase_q == 3'h4) ? 3'h0 : phase_q + 3'h1;
    end else if (i_go && i_en) begin
      phase_q <= 3'h1;
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign o_ext_memory_enable = i_en;
  assign o_address_active = (phase_q == 3'h1) || (phase_q == 3'h2);
  assign o_write_phase = phase_q[2] || (phase_q == 3'h3);
  // Released buses show the inverse of the valid value
  assign o_mem_addr_lo = o_address_active ? i_addr : ~i_addr;
  assign o_mem_data_out = o_write_phase ? i_data : ~i_data;
  assign o_wave = {cnt_q[0], cnt_q < 4'hc, cnt_q < 4'h9, cnt_q < 4'h5, cnt_q < 4'h3};
endmodule : pmux_far_model

// file: verif/tb_pmux_top.sv
/* Bench for pmux_top: AHB-Lite register tasks, far-side model, compares.
   Assumes a zero-wait slave; SPI enable and role are bench levels, SPI outputs held low. */
`timescale 1ns/1ps
module tb_pmux_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic en = 1'b0, go = 1'b0, legacy = 1'b0;
  logic t2_en = 1'b0, t1c_en = 1'b0, t1b_en = 1'b0, t1a_en = 1'b0, t0_en = 1'b0;
  logic [7:0] pa_pin = 8'h00, pb_pin = 8'h00;
  logic [7:0] far_addr = 8'ha5, far_data = 8'h3c;
  logic spi_en = 1'b0, spi_mstr = 1'b0;
  logic [31:0] rd;
  logic [2:0] cases [5] = '{3'b010, 3'b001, 3'b111, 3'b101, 3'b011};
  int srcs [5] = '{4, 3, 4, 5, 6};
  int errors = 0;
  int n_checks = 0;
  wire hready, hresp, mem_en, wrp, addr_act;
  wire [31:0] hrdata;
  wire [7:0] addr_lo, dout, mem_din, pa_out, pa_oe, pa_pu, pa_gate, pb_out, pb_oe, pb_pu;
  wire [4:0] wave, ctl;
  wire [3:0] spi_in;
  // Sources: waves, constant low, both bit 7 timers combined with latch bit 7 low (AND)
  wire [6:0] tw = {wave[4] & wave[3], 1'b0, wave};

  always #2.5 clk = ~clk;

  pmux_far_model i_far (.i_clk(clk), .i_arst_n(arst_n), .i_en(en), .i_go(go), .i_addr(far_addr),
    .i_data(far_data), .o_ext_memory_enable(mem_en), .o_write_phase(wrp), .o_address_active(addr_act),
    .o_mem_addr_lo(addr_lo), .o_mem_data_out(dout), .o_wave(wave));
  pmux_top i_dut (.i_clk(clk), .i_arst_n(arst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hready), .i_hwdata(hwdata), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_ext_memory_enable(mem_en), .i_write_phase(wrp),
    .i_address_active(addr_act), .i_mem_addr_lo(addr_lo), .i_mem_data_out(dout), .o_mem_data_in(mem_din),
    .i_timer2_compare_out(wave[4]), .i_timer2_compare_en(t2_en), .i_timer1_compare_c_out(wave[3]),
    .i_timer1_compare_c_en(t1c_en), .i_timer1_compare_b_out(wave[2]), .i_timer1_compare_b_en(t1b_en),
    .i_timer1_compare_a_out(wave[1]), .i_timer1_compare_a_en(t1a_en), .i_timer0_compare_out(wave[0]),
    .i_timer0_compare_en(t0_en), .i_legacy_mode(legacy), .i_spi_enable(spi_en), .i_spi_master(spi_mstr),
    .i_spi_slave_out(1'b0), .i_spi_master_out(1'b0), .i_spi_sck_out(1'b0), .o_spi_master_in(spi_in[3]),
    .o_spi_slave_in(spi_in[2]), .o_spi_sck_in(spi_in[1]), .o_spi_select_n(spi_in[0]),
    .o_timer_sync_mode(ctl[4]),
    .o_comparator_mux_enable(ctl[3]), .o_global_pullup_off(ctl[2]), .o_timer0_prescaler_reset(ctl[1]),
    .o_timer123_prescaler_reset(ctl[0]), .i_pa_pin(pa_pin), .o_pa_out(pa_out), .o_pa_oe(pa_oe),
    .o_pa_pullup(pa_pu), .o_pa_input_gate_override_enable(pa_gate), .i_pb_pin(pb_pin),
    .o_pb_out(pb_out), .o_pb_oe(pb_oe), .o_pb_pullup(pb_pu));

  ////////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] exp, input logic [31:0] act);
    n_checks++;
    if (act !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, act);
    end
  endtask : chk

  // Bounded wait for hready, or for the memory phase picked by sel
  task wait_on(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      if (sel != 0) #1;
      n++;
    end while ((sel == 0 ? hready : sel == 1 ? addr_act : wrp) !== 1'b1 && n < 20);
    if ((sel == 0 ? hready : sel == 1 ? addr_act : wrp) !== 1'b1) begin
      errors++;
      complete_run;
    end
  endtask : wait_on

  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    wait_on(0);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_on(0);
    rd = hrdata;
  endtask : bus

  task wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wreg

  task rreg(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(e, rd);
    chk(32'(hresp), 32'h0);
  endtask : rreg

  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // Pin bit b follows waveform s one edge later
  task track(input int b, input int s);
    logic e;
    repeat (8) begin
      e = tw[s];
      @(posedge clk);
      #1;
      chk(32'(e), 32'(pb_out[b]));
    end
  endtask : track

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rreg(8'h00, 32'h0);
    wreg(8'h00, 32'hff);
    rreg(8'h00, 32'h8f);
    chk(32'(ctl), 32'h1f);
    wreg(8'h40, 32'hff);
    rreg(8'h40, 32'h0);
    wreg(8'h00, 32'h0);
    $display("test registers done");
    wreg(8'h04, 32'h0f);
    wreg(8'h08, 32'hf5);
    settle;
    chk(32'(pa_oe), 32'h0f);
    chk(32'(pa_out), 32'hf5);
    chk(32'(pa_pu), 32'hf0);
    wreg(8'h00, 32'h04);
    settle;
    chk(32'(pa_pu), 32'h0);
    wreg(8'h00, 32'h0);
    $display("test port defaults done");
    @(posedge clk);
    en <= 1'b1;
    settle;
    chk(32'(pa_oe), 32'h0);
    chk(32'(pa_pu), 32'hf5);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wait_on(1);
    @(posedge clk);
    #1;
    chk(32'(pa_out), 32'ha5);
    chk(32'(pa_oe), 32'hff);
    wait_on(2);
    @(posedge clk);
    #1;
    chk(32'(pa_out), 32'h3c);
    chk(32'(pa_pu), 32'h0);
    wreg(8'h00, 32'h04);
    settle;
    chk(32'(pa_pu), 32'h0);
    wreg(8'h00, 32'h0);
    @(posedge clk);
    en <= 1'b0;
    pa_pin <= 8'h5a;
    pb_pin <= 8'hc3;
    repeat (4) @(posedge clk);
    #1;
    chk(32'(mem_din), 32'h5a);
    chk(32'(pa_gate), 32'h0);
    rreg(8'h0c, 32'h5a);
    rreg(8'h18, 32'hc3);
    chk(32'(spi_in), 32'h3);
    $display("test memory and pins done");
    wreg(8'h10, 32'h0f);
    wreg(8'h14, 32'h0f);
    settle;
    chk(32'(pb_oe), 32'h0f);
    @(posedge clk);
    spi_en <= 1'b1;
    settle;
    chk(32'(pb_oe), 32'h08);
    chk(32'(pb_pu), 32'h07);
    chk(32'(pb_out), 32'h07);
    @(posedge clk);
    spi_mstr <= 1'b1;
    settle;
    chk(32'(pb_oe), 32'h07);
    chk(32'(pb_pu), 32'h08);
    chk(32'(pb_out), 32'h09);
    @(posedge clk);
    spi_en <= 1'b0;
    $display("test spi pins done");
    wreg(8'h10, 32'hf0);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      {legacy, t2_en, t1c_en} <= cases[i];
      settle;
      track(7, srcs[i]);
    end
    @(posedge clk);
    {legacy, t2_en, t1c_en, t1b_en, t1a_en, t0_en} <= 6'b000111;
    settle;
    track(6, 2);
    track(5, 1);
    track(4, 0);
    $display("test timer outputs done");
    complete_run;
  end
endmodule : tb_pmux_top
